// ==== raea_pkg.sv ====
// constants, state codes and carrier types of the reset and self-load block
// assumes a 25 MHz reference clock; word addresses are 15-bit indexes
package raea_pkg;

	// timing
	localparam int unsigned CLK_PERIOD_NS   = 40;
	localparam int unsigned STRAP_DELAY_NS  = 200;
	localparam int unsigned STRAP_DELAY_CYC =
		(STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned IRQ_PULSE_NS    = 250;
	localparam int unsigned IRQ_PULSE_CYC   = IRQ_PULSE_NS / CLK_PERIOD_NS;
	localparam int unsigned MEMTEST_MAX_US  = 985;

	// word map
	localparam int unsigned RAM_WORDS       = 32768;
	localparam logic [14:0] IDX_CFG1        = 15'h0000;
	localparam logic [14:0] IDX_OPSTAT      = 15'h0002;
	localparam logic [14:0] IDX_PENDING     = 15'h0006;
	localparam logic [14:0] IDX_TIMETAG     = 15'h0008;
	localparam logic [14:0] IDX_BITWORD     = 15'h0014;
	localparam logic [14:0] IDX_FIRST_BAD   = 15'h001F;
	localparam logic [14:0] IDX_CHECKSUM    = 15'h0020;
	localparam logic [14:0] FULL_LAST_IDX   = 15'h7FFF;
	localparam logic [14:0] SHORT_LAST_IDX  = 15'h003F;
	localparam logic [15:0] MT_FIRST        = 16'h0020;
	localparam logic [15:0] MT_END          = 16'h8000;
	localparam logic [15:0] MT_DONE         = 16'h8002;
	localparam logic [15:0] MT_PATTERN      = 16'h5A5A;

	// register fields
	localparam int unsigned CFG1_RUN_BIT    = 0;
	localparam int unsigned CFG1_SOFT_RESET_BIT_BIT   = 1;
	localparam int unsigned OPS_READBACK_MISMATCH_FLAG_BIT   = 0;
	localparam int unsigned OPS_CHECKSUM_FAIL_FLAG_BIT   = 1;
	localparam int unsigned OPS_ADDRESS_PARITY_FAIL_FLAG_BIT   = 2;
	localparam int unsigned OPS_IRQSEL_BIT  = 3;
	localparam int unsigned BITW_LOADF_BIT  = 8;
	localparam int unsigned BITW_MEMF_BIT   = 9;
	localparam logic [15:0] CFG1_RESET      = 16'h0000;
	localparam logic [15:0] BITW_RESET      = 16'h0000;

	// serial memory port
	localparam logic [7:0]  SPI_READ_CMD    = 8'h03;
	localparam logic [4:0]  SPI_HDR_LAST    = 5'h17;
	localparam logic [4:0]  SPI_WORD_LAST   = 5'h0F;
	localparam logic [2:0]  SPI_DIV_LAST    = 3'h7;
	localparam logic [2:0]  SPI_SAMPLE_DIV  = 3'h6;

	typedef enum logic [6:0] {
		ST_HOLD   = 7'h01,
		ST_STRAP  = 7'h02,
		ST_MTEST  = 7'h04,
		ST_LOAD   = 7'h08,
		ST_SETTLE = 7'h10,
		ST_FINISH = 7'h20,
		ST_RUN    = 7'h40
	} raea_state_e;

	typedef struct packed {
		logic [4:0] term_addr;
		logic       addr_parity;
		logic       self_init;
		logic       lock;
		logic       irq_style;
		logic       mt_bypass;
		logic       short_image;
	} raea_strap_s;

	typedef struct packed {
		logic        write;
		logic        mapped;
		logic [14:0] idx;
	} raea_dphase_s;

endpackage : raea_pkg

// ==== raea_autoinit.sv ====
// master reset sequencer, memory test/clear and serial self-load, with AHB-Lite
// register access; assumes pins arrive asynchronously to i_ref_clk
//
// What this block does
// - rising edge of reset pin starts full reset; low pin holds all cleared but latched straps and word store
// - reset aborts command work, clears decoders, encoder and time-tag counter
// - reset clears error, busy, broadcast status; terminal flag left enabled
// - ready, active and both interrupt outputs negated during reset
// - 200 ns after release, straps latch into operating status register
// - before ready, every host read returns operating status
// - bypass low runs memory test; failure sets memory-test flag in word 0x14
// - bypass high skips test; words above 0x1F always cleared
// - self-init low skips load and raises ready for host setup
// - self-init high keeps ready low while loading from serial memory
// - short-image low loads words 0x0 through 0x7FFF
// - short-image high loads words up to 0x003F only
// - every loaded word is read back; mismatch recorded, acted upon at end
// - tally skips words 0x2, 0x6, 0x8, 0x14; checksum is two's complement
// - byte pairs fetched in order, merged, written and added to tally
// - zero final tally means good checksum, nonzero means failure
// - at ready the stored checksum word is placed at word 0x20
// - ready rises after load; error actions taken at that edge
// - soft reset bit requests a reset that spares configured state
// - each word arrives upper byte first, then lower byte
// - load error asserts hardware interrupt and sets status failure flag
// - loaded run bit with no load or address parity failure sets run enable automatically, even after a memory-test failure
`timescale 1ns/10ps
module raea_autoinit
	import raea_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	// strap and reset pins
	input  wire logic        i_hw_master_reset_pin_n,
	input  wire logic [4:0]  i_terminal_address_pins,
	input  wire logic        i_terminal_address_parity_pin,
	input  wire logic        i_self_init_select_pin,
	input  wire logic        i_lock_pin,
	input  wire logic        i_irq_style_select,
	input  wire logic        i_memtest_bypass_pin,
	input  wire logic        i_short_image_select_pin,
	input  wire logic        i_hw_irq_ack,
	// terminal core
	input  wire logic        i_core_active,
	input  wire logic        i_core_msg_irq_n,
	output logic             o_core_hold,
	output logic             o_soft_reset,
	output logic             o_run_enable_bit,
	// host pins
	output logic             o_ready,
	output logic             o_active,
	output logic             o_hw_event_irq_pin_n,
	output logic             o_msg_event_irq_pin_n,
	// serial memory port
	output logic             o_ee_sck,
	output logic             o_ee_cs_n,
	output logic             o_ee_mosi,
	input  wire logic        i_ee_miso,
	// AHB-Lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic [31:0]      o_hrdata
);

	function automatic logic [15:0] mt_pattern(input logic [15:0] a);
		mt_pattern = a ^ MT_PATTERN;
	endfunction : mt_pattern

	function automatic logic [14:0] idx_of(input logic [15:0] a);
		idx_of = a[14:0];
	endfunction : idx_of

	// odd parity across address and parity bit is correct
	function automatic logic parity_bad(input logic [5:0] a);
		parity_bad = ~(^a);
	endfunction : parity_bad

	function automatic logic tally_skip(input logic [14:0] i);
		tally_skip = (i == IDX_OPSTAT) || (i == IDX_PENDING) ||
			(i == IDX_TIMETAG) || (i == IDX_BITWORD);
	endfunction : tally_skip

	// two-flop synchronisers for all pins
	logic [10:0]  pin_meta_reg;
	logic [10:0]  pin_sync_reg;
	logic         mr_n_s;
	logic         ack_s;
	logic         miso_s;
	raea_strap_s  strap_pins;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_meta_reg <= 11'h000;
			pin_sync_reg <= 11'h000;
		end else begin
			pin_meta_reg <= {i_hw_master_reset_pin_n, i_hw_irq_ack, i_ee_miso,
				i_terminal_address_pins, i_terminal_address_parity_pin,
				i_self_init_select_pin, i_lock_pin};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// slow straps pass through their own pair of flops in a second bank
	logic [3:0] strap_meta_reg;
	logic [3:0] strap_sync_reg;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			strap_meta_reg <= 4'h0;
			strap_sync_reg <= 4'h0;
		end else begin
			strap_meta_reg <= {i_irq_style_select, i_memtest_bypass_pin,
				i_short_image_select_pin, 1'b0};
			strap_sync_reg <= strap_meta_reg;
		end
	end

	assign mr_n_s = pin_sync_reg[10];
	assign ack_s  = pin_sync_reg[9];
	assign miso_s = pin_sync_reg[8];
	assign strap_pins = {pin_sync_reg[7:0], strap_sync_reg[3:1]};

	// state and control
	raea_state_e  state_reg;
	raea_strap_s  strap_reg;
	logic [2:0]   wait_cnt_reg;
	logic [15:0]  mt_addr_reg;
	logic         mt_fail_reg;
	logic         ready_reg;
	logic [2:0]   div_reg;
	logic [4:0]   bit_cnt_reg;
	logic         hdr_reg;
	logic [23:0]  tx_reg;
	logic [15:0]  rx_reg;
	logic [14:0]  word_idx_reg;
	logic         vfy_pend_reg;
	logic [14:0]  vfy_idx_reg;
	logic [15:0]  vfy_word_reg;
	logic [15:0]  tally_reg;
	logic [15:0]  cks_word_reg;
	logic         mismatch_reg;
	logic [14:0]  first_bad_reg;
	logic         loaded_run_reg;
	logic [15:0]  cfg1_reg;
	logic [7:0]   ops_hi_reg;
	logic         ops_irqsel_reg;
	logic         ops_checksum_fail_flag_reg;
	logic         ops_readback_mismatch_flag_reg;
	logic [15:0]  bitw_reg;
	logic         irq_n_reg;
	logic [2:0]   irq_cnt_reg;
	logic [15:0]  ram_mem [0:RAM_WORDS-1];
	raea_dphase_s dp_reg;
	logic         dp_valid_reg;

	logic         mr_low;
	logic         bit_end;
	logic         word_done;
	logic [14:0]  last_idx;
	logic         load_err;
	logic         host_wr;
	logic         address_parity_fail_flag;
	logic [15:0]  ops_word;
	logic [14:0]  mt_a0;
	logic [14:0]  mt_a1;
	logic [14:0]  mt_p0;
	logic [14:0]  mt_p1;
	logic         mt_wr_en;
	logic         mt_chk_en;

	assign mr_low    = ~mr_n_s;
	assign bit_end   = (state_reg == ST_LOAD) && (div_reg == SPI_DIV_LAST);
	assign word_done = bit_end && !hdr_reg && (bit_cnt_reg == SPI_WORD_LAST);
	assign last_idx  = strap_reg.short_image ? SHORT_LAST_IDX
		: FULL_LAST_IDX;
	assign load_err  = (tally_reg != 16'h0000) || mismatch_reg;
	assign host_wr   = dp_valid_reg && dp_reg.write && dp_reg.mapped && ready_reg;
	assign address_parity_fail_flag     = parity_bad(ops_hi_reg[7:2]);
	assign ops_word  = {ops_hi_reg, 4'h0, ops_irqsel_reg, address_parity_fail_flag,
		ops_checksum_fail_flag_reg, ops_readback_mismatch_flag_reg};
	assign mt_a0     = idx_of(mt_addr_reg);
	assign mt_a1     = idx_of(mt_addr_reg + 16'h0001);
	assign mt_p0     = idx_of(mt_addr_reg - 16'h0002);
	assign mt_p1     = idx_of(mt_addr_reg - 16'h0001);
	assign mt_wr_en  = (state_reg == ST_MTEST) && (mt_addr_reg < MT_END);
	// bounded at MT_END: a check at MT_DONE would wrap onto words 0 and 1
	assign mt_chk_en = (state_reg == ST_MTEST) &&
		(mt_addr_reg >= MT_FIRST + 16'h0002) && (mt_addr_reg <= MT_END);

	// sequencer; a low reset pin forces the idle, cleared state
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg    <= ST_HOLD;
			wait_cnt_reg <= 3'h0;
			mt_addr_reg  <= MT_FIRST;
			strap_reg    <= '0;
		end else if (mr_low) begin
			state_reg    <= ST_HOLD;
			wait_cnt_reg <= 3'h0;
			mt_addr_reg  <= MT_FIRST;
		end else begin
			case (state_reg)
				ST_HOLD: begin
					state_reg <= ST_STRAP;
				end
				ST_STRAP: begin
					wait_cnt_reg <= wait_cnt_reg + 3'h1;
					if (wait_cnt_reg == 3'(STRAP_DELAY_CYC - 1)) begin
						strap_reg <= strap_pins;
						state_reg <= ST_MTEST;
					end
				end
				ST_MTEST: begin
					// two words per clock keeps the full pass near 655 us
					mt_addr_reg <= mt_addr_reg + 16'h0002;
					if (mt_addr_reg == MT_DONE) begin
						state_reg <= strap_reg.self_init ? ST_LOAD
							: ST_RUN;
					end
				end
				ST_LOAD: begin
					if (word_done && word_idx_reg == last_idx) begin
						state_reg <= ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					state_reg <= ST_FINISH;
				end
				ST_FINISH: begin
					state_reg <= ST_RUN;
				end
				ST_RUN: begin
					state_reg <= ST_RUN;
				end
				default: begin
					state_reg <= ST_HOLD;
				end
			endcase
		end
	end

	// ready, active and message interrupt held negated, core hold asserted, through reset
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			ready_reg             <= 1'b0;
			o_active              <= 1'b0;
			o_msg_event_irq_pin_n <= 1'b1;
			o_core_hold           <= 1'b1;
		end else begin
			ready_reg <= !mr_low && (state_reg == ST_RUN ||
				state_reg == ST_FINISH ||
				(state_reg == ST_MTEST && mt_addr_reg == MT_DONE &&
				!strap_reg.self_init));
			o_active              <= ready_reg && i_core_active;
			o_msg_event_irq_pin_n <= !ready_reg || i_core_msg_irq_n;
			// the core keeps its decoders, encoder, time-tag and status
			// bits cleared while held; terminal flag stays enabled
			o_core_hold           <= mr_low || !ready_reg;
		end
	end
	assign o_ready = ready_reg;

	// memory test result
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			mt_fail_reg <= 1'b0;
		end else if (mr_low) begin
			mt_fail_reg <= 1'b0;
		end else if (mt_chk_en && !strap_reg.mt_bypass) begin
			if (ram_mem[mt_p0] != mt_pattern(mt_addr_reg - 16'h0002) ||
				ram_mem[mt_p1] != mt_pattern(mt_addr_reg - 16'h0001)) begin
				mt_fail_reg <= 1'b1;
			end
		end
	end

	// serial memory framing: mode 0, eight reference clocks per bit
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			div_reg     <= 3'h0;
			bit_cnt_reg <= 5'h00;
			hdr_reg     <= 1'b1;
			tx_reg      <= 24'h000000;
			rx_reg      <= 16'h0000;
			o_ee_cs_n   <= 1'b1;
			o_ee_sck    <= 1'b0;
			o_ee_mosi   <= 1'b0;
		end else if (mr_low || state_reg != ST_LOAD) begin
			div_reg     <= 3'h0;
			bit_cnt_reg <= 5'h00;
			hdr_reg     <= 1'b1;
			o_ee_sck    <= 1'b0;
			o_ee_cs_n   <= !(state_reg == ST_MTEST && !mr_low &&
				mt_addr_reg == MT_DONE && strap_reg.self_init);
			tx_reg      <= {SPI_READ_CMD, 16'h0000};
			o_ee_mosi   <= !mr_low && state_reg == ST_MTEST && SPI_READ_CMD[7];
		end else begin
			div_reg  <= div_reg + 3'h1;
			o_ee_sck <= (div_reg >= 3'h3) && (div_reg <= 3'h6);
			if (word_done && word_idx_reg == last_idx) begin
				o_ee_cs_n <= 1'b1;
			end
			if (div_reg == SPI_SAMPLE_DIV) begin
				rx_reg <= {rx_reg[14:0], miso_s};
			end
			if (bit_end) begin
				if (hdr_reg) begin
					tx_reg    <= {tx_reg[22:0], 1'b0};
					o_ee_mosi <= tx_reg[22];
					bit_cnt_reg <= (bit_cnt_reg == SPI_HDR_LAST) ? 5'h00
						: bit_cnt_reg + 5'h01;
					hdr_reg   <= (bit_cnt_reg != SPI_HDR_LAST);
				end else begin
					o_ee_mosi <= 1'b0;
					bit_cnt_reg <= (bit_cnt_reg == SPI_WORD_LAST) ? 5'h00
						: bit_cnt_reg + 5'h01;
				end
			end
		end
	end

	// per-word bookkeeping: address, tally, read-back
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			word_idx_reg   <= 15'h0000;
			tally_reg      <= 16'h0000;
			cks_word_reg   <= 16'h0000;
			vfy_pend_reg   <= 1'b0;
			vfy_idx_reg    <= 15'h0000;
			vfy_word_reg   <= 16'h0000;
			mismatch_reg   <= 1'b0;
			first_bad_reg  <= 15'h0000;
			loaded_run_reg <= 1'b0;
		end else if (mr_low) begin
			word_idx_reg   <= 15'h0000;
			tally_reg      <= 16'h0000;
			vfy_pend_reg   <= 1'b0;
			mismatch_reg   <= 1'b0;
			loaded_run_reg <= 1'b0;
		end else begin
			vfy_pend_reg <= word_done;
			if (word_done) begin
				word_idx_reg <= word_idx_reg + 15'h0001;
				vfy_idx_reg  <= word_idx_reg;
				vfy_word_reg <= rx_reg;
				if (!tally_skip(word_idx_reg)) begin
					tally_reg <= tally_reg + rx_reg;
				end
				if (word_idx_reg == IDX_CHECKSUM) begin
					cks_word_reg <= rx_reg;
				end
				if (word_idx_reg == IDX_CFG1) begin
					loaded_run_reg <= rx_reg[CFG1_RUN_BIT];
				end
			end
			if (vfy_pend_reg && ram_mem[vfy_idx_reg] != vfy_word_reg) begin
				mismatch_reg <= 1'b1;
				if (!mismatch_reg) begin
					first_bad_reg <= vfy_idx_reg;
				end
			end
		end
	end

	// word store: test, clear, load, finish and host writes
	always_ff @(posedge i_ref_clk) begin
		if (mt_wr_en || mt_chk_en) begin
			if (mt_wr_en && !strap_reg.mt_bypass) begin
				ram_mem[mt_a0] <= mt_pattern(mt_addr_reg);
				ram_mem[mt_a1] <= mt_pattern(mt_addr_reg + 16'h0001);
			end
			if (mt_chk_en) begin
				ram_mem[mt_p0] <= 16'h0000;
				ram_mem[mt_p1] <= 16'h0000;
			end
		end else if (word_done) begin
			ram_mem[word_idx_reg] <= rx_reg;
		end else if (state_reg == ST_FINISH) begin
			ram_mem[IDX_CHECKSUM] <= cks_word_reg;
			if (mismatch_reg) begin
				ram_mem[IDX_FIRST_BAD] <= {1'b0, first_bad_reg};
			end
		end else if (host_wr) begin
			ram_mem[dp_reg.idx] <= i_hwdata[15:0];
		end
	end

	// configuration, status and built-in-test registers
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg1_reg       <= CFG1_RESET;
			ops_hi_reg     <= 8'h00;
			ops_irqsel_reg <= 1'b0;
			ops_checksum_fail_flag_reg  <= 1'b0;
			ops_readback_mismatch_flag_reg  <= 1'b0;
			bitw_reg       <= BITW_RESET;
			o_soft_reset   <= 1'b0;
		end else if (mr_low) begin
			cfg1_reg       <= CFG1_RESET;
			ops_checksum_fail_flag_reg  <= 1'b0;
			ops_readback_mismatch_flag_reg  <= 1'b0;
			bitw_reg       <= BITW_RESET;
			o_soft_reset   <= 1'b0;
		end else begin
			o_soft_reset <= 1'b0;
			if (state_reg == ST_STRAP &&
				wait_cnt_reg == 3'(STRAP_DELAY_CYC - 1)) begin
				ops_hi_reg     <= {strap_pins.term_addr, strap_pins.addr_parity,
					strap_pins.self_init, strap_pins.lock};
				ops_irqsel_reg <= strap_pins.irq_style;
			end
			if (state_reg == ST_MTEST && mt_addr_reg == MT_DONE) begin
				bitw_reg[BITW_MEMF_BIT] <= mt_fail_reg;
			end
			if (word_done) begin
				if (word_idx_reg == IDX_CFG1) begin
					cfg1_reg <= rx_reg & ~(16'h0001 << CFG1_RUN_BIT)
						& ~(16'h0001 << CFG1_SOFT_RESET_BIT_BIT);
				end
				if (word_idx_reg == IDX_OPSTAT && !strap_reg.lock) begin
					ops_hi_reg <= rx_reg[15:8];
				end
				if (word_idx_reg == IDX_BITWORD) begin
					bitw_reg <= rx_reg;
					// the image cannot know this run's memory test result
					bitw_reg[BITW_MEMF_BIT] <= bitw_reg[BITW_MEMF_BIT];
				end
			end
			if (state_reg == ST_FINISH) begin
				ops_checksum_fail_flag_reg <= (tally_reg != 16'h0000);
				ops_readback_mismatch_flag_reg <= mismatch_reg;
				if (load_err) begin
					bitw_reg[BITW_LOADF_BIT] <= 1'b1;
				end
				if (loaded_run_reg && !load_err && !address_parity_fail_flag) begin
					cfg1_reg[CFG1_RUN_BIT] <= 1'b1;
				end
			end
			if (host_wr && dp_reg.idx == IDX_CFG1) begin
				cfg1_reg <= i_hwdata[15:0] & ~(16'h0001 << CFG1_SOFT_RESET_BIT_BIT);
				if (address_parity_fail_flag) begin
					cfg1_reg[CFG1_RUN_BIT] <= cfg1_reg[CFG1_RUN_BIT];
				end
				if (i_hwdata[CFG1_SOFT_RESET_BIT_BIT]) begin
					o_soft_reset <= 1'b1;
					bitw_reg     <= BITW_RESET;
				end
			end
			if (host_wr && dp_reg.idx == IDX_OPSTAT) begin
				ops_hi_reg[7:2] <= i_hwdata[15:10];
			end
			if (host_wr && dp_reg.idx == IDX_BITWORD) begin
				bitw_reg <= i_hwdata[15:0];
			end
		end
	end
	assign o_run_enable_bit = cfg1_reg[CFG1_RUN_BIT];

	// hardware interrupt: pulse or level until acknowledged
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_n_reg   <= 1'b1;
			irq_cnt_reg <= 3'h0;
		end else if (mr_low) begin
			irq_n_reg   <= 1'b1;
			irq_cnt_reg <= 3'h0;
		end else if (state_reg == ST_FINISH && load_err) begin
			irq_n_reg   <= 1'b0;
			irq_cnt_reg <= 3'(IRQ_PULSE_CYC - 1);
		end else if (!irq_n_reg) begin
			if (ops_irqsel_reg) begin
				irq_n_reg <= ack_s;
			end else begin
				irq_cnt_reg <= irq_cnt_reg - 3'h1;
				irq_n_reg   <= (irq_cnt_reg == 3'h0);
			end
		end
	end
	assign o_hw_event_irq_pin_n = irq_n_reg;

	// AHB-Lite slave, zero wait states, always OKAY
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			dp_valid_reg <= 1'b0;
			dp_reg       <= '0;
			o_hrdata     <= 32'h00000000;
		end else begin
			dp_valid_reg <= i_hsel && i_htrans[1] && i_hready;
			if (i_hsel && i_htrans[1] && i_hready) begin
				dp_reg.write  <= i_hwrite;
				dp_reg.mapped <= (i_haddr[31:17] == 15'h0000);
				dp_reg.idx    <= i_haddr[16:2];
				if (i_hwrite) begin
					o_hrdata <= 32'h00000000;
				end else if (!ready_reg) begin
					o_hrdata <= {16'h0000, ops_word};
				end else if (i_haddr[31:17] != 15'h0000) begin
					o_hrdata <= 32'h00000000;
				end else if (i_haddr[16:2] == IDX_CFG1) begin
					o_hrdata <= {16'h0000, cfg1_reg};
				end else if (i_haddr[16:2] == IDX_OPSTAT) begin
					o_hrdata <= {16'h0000, ops_word};
				end else if (i_haddr[16:2] == IDX_BITWORD) begin
					o_hrdata <= {16'h0000, bitw_reg};
				end else begin
					o_hrdata <= {16'h0000, ram_mem[i_haddr[16:2]]};
				end
			end
		end
	end
	assign o_hreadyout = 1'b1;
	assign o_hresp     = 1'b0;

endmodule : raea_autoinit

// ==== raea_sva.sv ====
// checker on the reset sequencer pins and serial port timing
// assumes it is bound into raea_autoinit, one clock domain
`timescale 1ns/10ps
module raea_sva (
	// clock, reset and pins watched
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_hw_master_reset_pin_n,
	input wire logic i_irq_style_select,
	// outputs watched
	input wire logic o_core_hold,
	input wire logic o_soft_reset,
	input wire logic o_run_enable_bit,
	input wire logic o_ready,
	input wire logic o_active,
	input wire logic o_hw_event_irq_pin_n,
	input wire logic o_msg_event_irq_pin_n,
	input wire logic o_ee_sck,
	input wire logic o_ee_cs_n
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	sequence s_sck_high;
		o_ee_sck [*4] ##1 !o_ee_sck;
	endsequence
	sequence s_irq_pulse;
		!o_hw_event_irq_pin_n [*6] ##1 o_hw_event_irq_pin_n;
	endsequence
	// pin must be seen low long enough to pass the synchroniser
	property p_pin_low;
		!i_hw_master_reset_pin_n [*5] |-> !o_ready && !o_active &&
			o_hw_event_irq_pin_n && o_msg_event_irq_pin_n;
	endproperty
	property p_hold;
		!o_ready |-> o_core_hold;
	endproperty
	property p_active;
		o_active |-> o_ready || $past(o_ready);
	endproperty
	property p_load_quiet;
		!o_ee_cs_n |-> !o_ready;
	endproperty
	property p_sck_idle;
		o_ee_cs_n |-> !o_ee_sck;
	endproperty
	property p_sck;
		$rose(o_ee_sck) |-> s_sck_high;
	endproperty
	property p_irq_at_ready;
		$fell(o_hw_event_irq_pin_n) |-> $rose(o_ready);
	endproperty
	property p_irq_pulse;
		$fell(o_hw_event_irq_pin_n) && !i_irq_style_select |-> s_irq_pulse;
	endproperty
	property p_run;
		o_run_enable_bit |-> o_ready;
	endproperty
	property p_soft_reset_bit;
		o_soft_reset |=> !o_soft_reset;
	endproperty
	a_pin_low: assert property (p_pin_low)
		else $error("outputs not negated in master reset");
	a_hold: assert property (p_hold)
		else $error("core hold low before ready");
	a_active: assert property (p_active)
		else $error("active without ready");
	a_load_quiet: assert property (p_load_quiet)
		else $error("ready high during load");
	a_sck_idle: assert property (p_sck_idle)
		else $error("serial clock high while deselected");
	a_sck: assert property (p_sck)
		else $error("serial clock high time wrong");
	a_irq_at_ready: assert property (p_irq_at_ready)
		else $error("interrupt not on ready edge");
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("interrupt pulse width wrong");
	a_run: assert property (p_run)
		else $error("run enable before ready");
	a_soft_reset_bit: assert property (p_soft_reset_bit)
		else $error("soft reset pulse too long");
endmodule : raea_sva
bind raea_autoinit raea_sva u_sva (.*);

// ==== raea_eeprom_model.sv ====
// serial memory model holding a short load image
// assumes mode 0 reads starting at byte 0, one stream per select
`timescale 1ns/10ps
module raea_eeprom_model (
	// serial pins
	input  wire logic   i_sck,
	input  wire logic   i_cs_n,
	input  wire logic   i_mosi,
	output logic        o_miso,
	// image choice and captured header
	input  wire logic   i_bad,
	output logic [23:0] o_hdr
);
	int          bitn = 0;
	int          k;
	logic [15:0] w;
	function automatic logic [15:0] word(input int i);
		if (i == 0)
			return 16'h0001;
		if (i == 32)
			return i_bad ? 16'hFA2E : 16'hFA2F;
		if (i > 32 && i < 64)
			return 16'(i);
		return 16'h0000;
	endfunction : word
	initial o_miso = 1'h0;
	initial o_hdr = 24'h000000;
	always @(negedge i_cs_n) bitn = 0;
	always @(posedge i_sck) begin
		if (!i_cs_n) begin
			if (bitn < 24)
				o_hdr <= {o_hdr[22:0], i_mosi};
			bitn = bitn + 1;
		end
	end
	// released line has no pull, so it keeps changing
	always @(negedge i_sck or posedge i_cs_n) begin
		k = bitn - 24;
		w = word(k / 16);
		if (i_cs_n)
			o_miso = ~o_miso;
		else if (k >= 0)
			o_miso = w[15 - k % 16];
	end
endmodule : raea_eeprom_model

// ==== testbench.sv ====
// self-checking bench: host setup, good load and bad checksum load
// assumes zero-wait bus slave and the model image in raea_eeprom_model
`timescale 1ns/10ps
module testbench;
	import raea_pkg::*;
	logic i_ref_clk, i_rst, i_hw_master_reset_pin_n, i_ee_miso, bad;
	logic [4:0] i_terminal_address_pins;
	logic i_terminal_address_parity_pin, i_self_init_select_pin;
	logic i_memtest_bypass_pin, i_short_image_select_pin, i_lock_pin;
	logic i_irq_style_select, i_hw_irq_ack, i_core_active;
	logic i_core_msg_irq_n, i_hsel, i_hwrite, i_hready;
	logic [31:0] i_haddr, i_hwdata, o_hrdata;
	logic [1:0] i_htrans;
	logic [2:0] i_hsize;
	logic o_core_hold, o_soft_reset, o_run_enable_bit, o_ready;
	logic o_active, o_hw_event_irq_pin_n, o_msg_event_irq_pin_n;
	logic o_ee_sck, o_ee_cs_n, o_ee_mosi, o_hreadyout, o_hresp;
	logic [23:0] hdr;
	int mismatches = 0;
	int comparisons = 0;
	assign i_hready = o_hreadyout;
	raea_autoinit dut (.*);
	raea_eeprom_model ee (.i_sck(o_ee_sck), .i_cs_n(o_ee_cs_n),
		.i_mosi(o_ee_mosi), .o_miso(i_ee_miso), .i_bad(bad), .o_hdr(hdr));
	task automatic end_of_test;
		if (mismatches == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [31:0] ba(input logic [14:0] idx);
		return {15'h0000, idx, 2'h0};
	endfunction : ba
	task automatic rdy;
		int n;
		n = 0;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (o_hreadyout !== 1'h1 && n < 16);
		if (o_hreadyout !== 1'h1) begin
			chk(32'h0, 32'h1);
			end_of_test();
		end
	endtask : rdy
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [15:0] wd, output logic [31:0] rd);
		@(posedge i_ref_clk);
		i_hsel <= 1'h1;
		i_htrans <= 2'h2;
		i_hwrite <= wr;
		i_hsize <= 3'h2;
		i_haddr <= a;
		rdy();
		i_hsel <= 1'h0;
		i_htrans <= 2'h0;
		i_hwdata <= {16'h0000, wd};
		rdy();
		rd = o_hrdata;
	endtask : bus
	task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp);
		logic [31:0] v;
		bus(1'h0, a, 16'h0000, v);
		chk(v, {16'h0000, exp});
	endtask : rd_chk
	task automatic wr(input logic [14:0] idx, input logic [15:0] d);
		logic [31:0] v;
		bus(1'h1, ba(idx), d, v);
		repeat (2) @(negedge i_ref_clk);
	endtask : wr
	task automatic wait_ready;
		for (int n = 0; n < 40000 && o_ready !== 1'h1; n++)
			@(negedge i_ref_clk);
		if (o_ready !== 1'h1) begin
			chk(32'h0, 32'h1);
			end_of_test();
		end
	endtask : wait_ready
	task automatic restart(input logic si, input logic sh, input logic bp,
		input logic b);
		@(posedge i_ref_clk);
		i_hw_master_reset_pin_n <= 1'h0;
		i_self_init_select_pin <= si;
		i_short_image_select_pin <= sh;
		i_memtest_bypass_pin <= bp;
		bad <= b;
		repeat (8) @(posedge i_ref_clk);
		chk(32'({o_ready, o_active, o_core_hold}), 32'h1);
		i_hw_master_reset_pin_n <= 1'h1;
		repeat (20) @(posedge i_ref_clk);
	endtask : restart
	task automatic host_mode;
		restart(1'h0, 1'h0, 1'h1, 1'h0);
		rd_chk(ba(15'h1234), 16'h5500);
		rd_chk(ba(IDX_OPSTAT), 16'h5500);
		wait_ready();
		rd_chk(ba(15'h0025), 16'h0000);
		chk(32'({o_active, o_core_hold, o_msg_event_irq_pin_n, o_hresp}),
			32'hA);
		rd_chk(32'h0002_0008, 16'h0000);
		wr(15'h0025, 16'hBEEF);
		wr(IDX_BITWORD, 16'h0100);
		wr(IDX_CFG1, 16'h0001);
		chk(32'(o_run_enable_bit), 32'h1);
		wr(IDX_CFG1, 16'h0002);
		rd_chk(ba(15'h0025), 16'hBEEF);
		rd_chk(ba(IDX_BITWORD), 16'h0000);
	endtask : host_mode
	task automatic self_load(input logic b);
		i_irq_style_select <= b;
		restart(1'h1, 1'h1, 1'h0, b);
		rd_chk(ba(15'h0011), {12'h570, b, 3'h0});
		wait_ready();
		chk(32'(o_hw_event_irq_pin_n), 32'(!b));
		chk(32'(o_run_enable_bit), 32'(!b));
		chk(32'(hdr), 32'h0003_0000);
		rd_chk(ba(IDX_CHECKSUM), b ? 16'hFA2E : 16'hFA2F);
		rd_chk(ba(15'h0025), 16'h0025);
		rd_chk(ba(SHORT_LAST_IDX), 16'h003F);
		rd_chk(ba(IDX_OPSTAT), {12'h570, b, 1'h0, b, 1'h0});
		rd_chk(ba(IDX_BITWORD), {7'h00, b, 8'h00});
		if (b) begin
			chk(32'(o_hw_event_irq_pin_n), 32'h0);
			@(posedge i_ref_clk);
			i_hw_irq_ack <= 1'h1;
			repeat (4) @(posedge i_ref_clk);
			i_hw_irq_ack <= 1'h0;
			@(negedge i_ref_clk);
			chk(32'(o_hw_event_irq_pin_n), 32'h1);
		end
	endtask : self_load
	initial begin
		i_ref_clk = 1'h0;
		forever #20 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		i_rst = 1'h1;
		i_hw_master_reset_pin_n = 1'h0;
		i_terminal_address_pins = 5'h0A;
		i_terminal_address_parity_pin = 1'h1;
		i_self_init_select_pin = 1'h0;
		i_memtest_bypass_pin = 1'h1;
		i_short_image_select_pin = 1'h0;
		i_lock_pin = 1'h1;
		i_irq_style_select = 1'h0;
		i_hw_irq_ack = 1'h0;
		i_core_active = 1'h1;
		i_core_msg_irq_n = 1'h1;
		i_hsel = 1'h0;
		i_hwrite = 1'h0;
		i_haddr = 32'h0;
		i_hwdata = 32'h0;
		i_htrans = 2'h0;
		i_hsize = 3'h2;
		bad = 1'h0;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'h0;
		host_mode();
		self_load(1'h0);
		self_load(1'h1);
		end_of_test();
	end
endmodule : testbench
